// ==== hdl/ctt_pkg.sv ====
package ctt_pkg;
    // clock rate and printed times
    localparam longint CLK_HZ       = 50_000_000;
    localparam longint T_TERM_MS    = 32;
    localparam longint T_READY_MS   = 500;
    localparam longint T_QUAL_MS    = 30;
    localparam longint T_ALIVE_S    = 32;
    localparam longint T_UNATT_MIN  = 15;
    // register indexes
    localparam logic [2:0] IDX_STATUS  = 3'h0;
    localparam logic [2:0] IDX_CONTROL = 3'h1;
    localparam logic [2:0] IDX_CURRENT = 3'h4;
    // field positions
    localparam int KICK_BIT  = 7;
    localparam int ILIM_HI   = 7;
    localparam int ILIM_LO   = 6;
    localparam int WEAK_HI   = 5;
    localparam int WEAK_LO   = 4;
    localparam int TE_BIT    = 3;
    localparam int CDIS_BIT  = 2;
    localparam int HZ_BIT    = 1;
    localparam int ICHG_HI   = 6;
    localparam int ICHG_LO   = 4;
    localparam int ITRM_HI   = 2;
    localparam int ITRM_LO   = 0;
    // codes
    localparam logic [2:0] FAULT_NONE  = 3'h0;
    localparam logic [2:0] FAULT_TIMER = 3'h6;
    localparam logic [1:0] CS_READY    = 2'h0;
    localparam logic [1:0] CS_CHARGE   = 2'h1;
    localparam logic [1:0] CS_DONE     = 2'h2;
    localparam logic [1:0] CS_FAULT    = 2'h3;
    localparam logic [1:0] ILIM_100    = 2'h0;
    localparam logic [1:0] ILIM_500    = 2'h1;
    // thresholds in tenths of a millivolt, limits in mA (0 = no limit)
    localparam logic [9:0] ICHG_BASE   = 10'h176;
    localparam logic [9:0] ICHG_STEP   = 10'h044;
    localparam logic [9:0] ITRM_STEP_A = 10'h022;
    localparam logic [9:0] ITRM_STEP_B = 10'h021;
    localparam logic [9:0] LIM_MA_100  = 10'h064;
    localparam logic [9:0] LIM_MA_500  = 10'h1f4;
    localparam logic [9:0] LIM_MA_800  = 10'h320;
    localparam logic [9:0] LIM_MA_NONE = 10'h000;

    typedef struct packed {
        logic [1:0] input_limit_code;
        logic [1:0] weak_battery_threshold;
        logic       termination_enable_bit;
        logic       charge_disable;
        logic       high_impedance;
        logic [2:0] charge_current_code;
        logic [2:0] termination_current_code;
    } ctt_regs_t;

    localparam ctt_regs_t REGS_DEFAULT = '{default: '0};

    typedef struct packed {
        logic       valid;
        logic [2:0] index;
        logic [7:0] data;
    } ctt_wr_t;

    typedef struct packed {
        logic vbus_above_valid;
        logic vbus_above_ovp;
        logic below_termination;
        logic battery_present;
        logic source_present;
        logic battery_weak;
        logic recharge_request;
    } ctt_sense_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_QUALIFY = 3'b001,
        ST_CHARGE  = 3'b010,
        ST_READY   = 3'b011,
        ST_DONE    = 3'b100
    } ctt_state_t;

    typedef enum logic [1:0] {
        TM_NONE  = 2'b00,
        TM_UNATT = 2'b01,
        TM_ALIVE = 2'b10
    } ctt_tmode_t;
endpackage

// ==== hdl/ctt_charger.sv ====
`timescale 1ns/100ps
`default_nettype none
module ctt_charger #(
    parameter bit          AUTO_START = 1'b1,
    parameter bit          TERM_STEP_B = 1'b0,
    parameter logic [35:0] TERM_CYC  = 36'(ctt_pkg::CLK_HZ * ctt_pkg::T_TERM_MS / 1000),
    parameter logic [35:0] READY_CYC = 36'(ctt_pkg::CLK_HZ * ctt_pkg::T_READY_MS / 1000),
    parameter logic [35:0] QUAL_CYC  = 36'(ctt_pkg::CLK_HZ * ctt_pkg::T_QUAL_MS / 1000),
    parameter logic [35:0] ALIVE_CYC = 36'(ctt_pkg::CLK_HZ * ctt_pkg::T_ALIVE_S),
    parameter logic [35:0] UNATT_CYC = 36'(ctt_pkg::CLK_HZ * ctt_pkg::T_UNATT_MIN * 60)
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    // host register writes
    input  wire ctt_pkg::ctt_wr_t    host_wr,
    // analog comparators and pins
    input  wire ctt_pkg::ctt_sense_t sense,
    input  wire logic                port_select_pin,
    // charger control
    output logic                     charge_en,
    output logic                     discharge_load_en,
    output logic                     stat_pulse,
    output logic [1:0]               charge_state,
    output logic [2:0]               fault_code,
    output ctt_pkg::ctt_regs_t       regs,
    // decoded analog settings
    output logic [9:0]               charge_thresh_tenth_mv,
    output logic [9:0]               term_thresh_tenth_mv,
    output logic [1:0]               input_limit_code,
    output logic [9:0]               input_limit_ma
);
    ctt_pkg::ctt_state_t state_q;
    ctt_pkg::ctt_tmode_t tmode_q;
    ctt_pkg::ctt_regs_t  regs_q;
    logic [35:0]         cnt_q;
    logic [35:0]         tmr_q;
    logic                boot_q;
    logic [2:0]          fault_q;
    logic                stat_q;
    logic                vbus_ok;
    logic                alive_exp;
    logic                unatt_exp;
    logic                boot_start;
    logic                host_start;
    logic                ctrl_wr;
    logic                kick;
    logic                term_hit;
    logic                ready_end;
    logic [1:0]          lim_code;

    // input window and event decode
    assign vbus_ok    = sense.vbus_above_valid & ~sense.vbus_above_ovp;
    assign alive_exp  = (tmode_q == ctt_pkg::TM_ALIVE) && (tmr_q >= ALIVE_CYC - 36'h1);
    assign unatt_exp  = (tmode_q == ctt_pkg::TM_UNATT) && (tmr_q >= UNATT_CYC - 36'h1);
    assign boot_start = ~boot_q & AUTO_START;
    assign ctrl_wr    = host_wr.valid && (host_wr.index == ctt_pkg::IDX_CONTROL);
    assign host_start = ctrl_wr && !host_wr.data[ctt_pkg::CDIS_BIT] && !host_wr.data[ctt_pkg::HZ_BIT];
    assign kick       = host_wr.valid && (host_wr.index == ctt_pkg::IDX_STATUS)
                        && host_wr.data[ctt_pkg::KICK_BIT];
    assign term_hit   = regs_q.termination_enable_bit && sense.below_termination
                        && (cnt_q >= TERM_CYC - 36'h1);
    assign ready_end  = cnt_q >= READY_CYC - 36'h1;

    // boot flag caught one edge after reset release
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            boot_q <= 1'b0;
        else
            boot_q <= 1'b1;
    end

    // register file: host writes, default reload, charger disable on timeout
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            regs_q <= ctt_pkg::REGS_DEFAULT;
        else if (unatt_exp)
            regs_q.charge_disable <= 1'b1;
        else if (alive_exp || (boot_start && sense.battery_weak))
            regs_q <= ctt_pkg::REGS_DEFAULT;
        else if (ctrl_wr)
        begin
            regs_q.input_limit_code       <= host_wr.data[ctt_pkg::ILIM_HI:ctt_pkg::ILIM_LO];
            regs_q.weak_battery_threshold <= host_wr.data[ctt_pkg::WEAK_HI:ctt_pkg::WEAK_LO];
            regs_q.termination_enable_bit <= host_wr.data[ctt_pkg::TE_BIT];
            regs_q.charge_disable         <= host_wr.data[ctt_pkg::CDIS_BIT];
            regs_q.high_impedance         <= host_wr.data[ctt_pkg::HZ_BIT];
        end
        else if (host_wr.valid && (host_wr.index == ctt_pkg::IDX_CURRENT))
        begin
            regs_q.charge_current_code      <= host_wr.data[ctt_pkg::ICHG_HI:ctt_pkg::ICHG_LO];
            regs_q.termination_current_code <= host_wr.data[ctt_pkg::ITRM_HI:ctt_pkg::ITRM_LO];
        end
    end

    // safety timers: unattended and host-alive share one counter
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tmode_q <= ctt_pkg::TM_NONE;
            tmr_q   <= '0;
        end
        else if (unatt_exp)
        begin
            tmode_q <= ctt_pkg::TM_NONE;
            tmr_q   <= '0;
        end
        else if (host_wr.valid)
        begin
            tmode_q <= ctt_pkg::TM_ALIVE;
            tmr_q   <= '0;
        end
        else if (alive_exp)
        begin
            tmode_q <= ctt_pkg::TM_UNATT;
            tmr_q   <= '0;
        end
        else if ((tmode_q == ctt_pkg::TM_NONE) && (state_q == ctt_pkg::ST_QUALIFY)
                 && vbus_ok && (cnt_q >= QUAL_CYC - 36'h1))
        begin
            tmode_q <= ctt_pkg::TM_UNATT;
            tmr_q   <= '0;
        end
        else if (tmode_q != ctt_pkg::TM_NONE)
            tmr_q <= tmr_q + 36'h1;
    end

    // charge sequence: validate, charge, qualify termination, ready, done
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ctt_pkg::ST_IDLE;
            cnt_q   <= '0;
        end
        else if (unatt_exp)
        begin
            state_q <= ctt_pkg::ST_IDLE;
            cnt_q   <= '0;
        end
        else if (alive_exp || boot_start
                 || (host_start && ((state_q == ctt_pkg::ST_IDLE) || (state_q == ctt_pkg::ST_DONE))))
        begin
            state_q <= ctt_pkg::ST_QUALIFY;
            cnt_q   <= '0;
        end
        else
        begin
            case (state_q)
                ctt_pkg::ST_IDLE:
                    cnt_q <= '0;
                ctt_pkg::ST_QUALIFY:
                    if (!vbus_ok)
                        cnt_q <= '0;
                    else if (cnt_q >= QUAL_CYC - 36'h1)
                    begin
                        state_q <= ctt_pkg::ST_CHARGE;
                        cnt_q   <= '0;
                    end
                    else
                        cnt_q <= cnt_q + 36'h1;
                ctt_pkg::ST_CHARGE:
                    if (!vbus_ok)
                    begin
                        state_q <= ctt_pkg::ST_QUALIFY;
                        cnt_q   <= '0;
                    end
                    else if (term_hit)
                    begin
                        state_q <= ctt_pkg::ST_READY;
                        cnt_q   <= '0;
                    end
                    else if (regs_q.termination_enable_bit && sense.below_termination)
                        cnt_q <= cnt_q + 36'h1;
                    else
                        cnt_q <= '0;
                ctt_pkg::ST_READY:
                    if (ready_end)
                    begin
                        state_q <= (sense.battery_present && sense.source_present)
                                   ? ctt_pkg::ST_DONE : ctt_pkg::ST_IDLE;
                        cnt_q   <= '0;
                    end
                    else
                        cnt_q <= cnt_q + 36'h1;
                ctt_pkg::ST_DONE:
                    if (sense.recharge_request)
                    begin
                        state_q <= ctt_pkg::ST_QUALIFY;
                        cnt_q   <= '0;
                    end
                default:
                begin
                    state_q <= ctt_pkg::ST_IDLE;
                    cnt_q   <= '0;
                end
            endcase
        end
    end

    // fault field and status pulse
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_q <= ctt_pkg::FAULT_NONE;
            stat_q  <= 1'b0;
        end
        else
        begin
            stat_q <= alive_exp;
            if (alive_exp || unatt_exp)
                fault_q <= ctt_pkg::FAULT_TIMER;
            else if (host_start)
                fault_q <= ctt_pkg::FAULT_NONE;
        end
    end

    // effective input limit: pin while unattended on auto-start parts
    always_comb
    begin
        if (AUTO_START && (tmode_q == ctt_pkg::TM_UNATT))
            lim_code = port_select_pin ? ctt_pkg::ILIM_500 : ctt_pkg::ILIM_100;
        else
            lim_code = regs_q.input_limit_code;
    end

    // registered analog setting decode
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            charge_thresh_tenth_mv <= ctt_pkg::ICHG_BASE;
            term_thresh_tenth_mv   <= ctt_pkg::ITRM_STEP_A;
            input_limit_code       <= ctt_pkg::ILIM_100;
            input_limit_ma         <= ctt_pkg::LIM_MA_100;
        end
        else
        begin
            charge_thresh_tenth_mv <= 10'(ctt_pkg::ICHG_BASE
                                      + ctt_pkg::ICHG_STEP * 10'(regs_q.charge_current_code));
            term_thresh_tenth_mv   <= 10'((TERM_STEP_B ? ctt_pkg::ITRM_STEP_B : ctt_pkg::ITRM_STEP_A)
                                      * (10'(regs_q.termination_current_code) + 10'h1));
            input_limit_code       <= lim_code;
            case (lim_code)
                2'h0:    input_limit_ma <= ctt_pkg::LIM_MA_100;
                2'h1:    input_limit_ma <= ctt_pkg::LIM_MA_500;
                2'h2:    input_limit_ma <= ctt_pkg::LIM_MA_800;
                default: input_limit_ma <= ctt_pkg::LIM_MA_NONE;
            endcase
        end
    end

    // outputs
    assign charge_en         = (state_q == ctt_pkg::ST_CHARGE) && !regs_q.charge_disable;
    assign discharge_load_en = (state_q == ctt_pkg::ST_QUALIFY) && sense.vbus_above_valid;
    assign stat_pulse        = stat_q;
    assign fault_code        = fault_q;
    assign regs              = regs_q;
    always_comb
    begin
        case (state_q)
            ctt_pkg::ST_CHARGE: charge_state = ctt_pkg::CS_CHARGE;
            ctt_pkg::ST_READY:  charge_state = ctt_pkg::CS_READY;
            ctt_pkg::ST_DONE:   charge_state = ctt_pkg::CS_DONE;
            default:            charge_state = (fault_q == ctt_pkg::FAULT_TIMER)
                                               ? ctt_pkg::CS_FAULT : ctt_pkg::CS_READY;
        endcase
    end

    // checks
    chk_term_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ctt_pkg::ST_CHARGE && !regs_q.termination_enable_bit && !unatt_exp)
        |=> state_q != ctt_pkg::ST_READY)
        else $error("termination while disabled");
    chk_ready_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(state_q == ctt_pkg::ST_READY) |-> $past(sense.below_termination) && charge_state == ctt_pkg::CS_READY)
        else $error("ready entered without low current");
    chk_done_conn: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(state_q == ctt_pkg::ST_DONE) |-> $past(sense.battery_present) && $past(sense.source_present))
        else $error("done without connections");
    chk_qual_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ctt_pkg::ST_QUALIFY && !vbus_ok) |=> cnt_q == 36'h0)
        else $error("qualify count not restarted");
    chk_load_qualify: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ctt_pkg::ST_QUALIFY && sense.vbus_above_valid) |-> discharge_load_en && !charge_en)
        else $error("discharge load missing");
    chk_write_alive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (host_wr.valid && !unatt_exp) |=> tmode_q == ctt_pkg::TM_ALIVE && tmr_q == 36'h0)
        else $error("write did not start host-alive timer");
    chk_kick_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (kick && !unatt_exp) |=> tmode_q == ctt_pkg::TM_ALIVE && tmr_q == 36'h0)
        else $error("kick did not restart host-alive timer");
    chk_alive_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
        alive_exp |=> stat_pulse && fault_code == ctt_pkg::FAULT_TIMER ##1 !stat_pulse)
        else $error("host-alive expiry not reported");
    chk_alive_resume: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (alive_exp && !host_wr.valid) |=> state_q == ctt_pkg::ST_QUALIFY && tmode_q == ctt_pkg::TM_UNATT)
        else $error("charging not resumed on defaults");
    chk_unatt_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        unatt_exp |=> state_q == ctt_pkg::ST_IDLE && regs_q.charge_disable && !charge_en)
        else $error("unattended expiry did not stop charger");
    chk_limit_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (AUTO_START && tmode_q == ctt_pkg::TM_UNATT && port_select_pin) |=> input_limit_ma == ctt_pkg::LIM_MA_500)
        else $error("input limit does not follow pin");
    chk_charge_qual: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(state_q == ctt_pkg::ST_CHARGE) |-> $past(state_q) == ctt_pkg::ST_QUALIFY)
        else $error("charge began without validation");
    cov_done: cover property (@(posedge clk_sys) disable iff (!rst_n) state_q == ctt_pkg::ST_DONE);
    cov_alive: cover property (@(posedge clk_sys) disable iff (!rst_n) alive_exp);
    cov_unatt: cover property (@(posedge clk_sys) disable iff (!rst_n) unatt_exp);
endmodule // ctt_charger
`default_nettype wire

// ==== tb/ctt_source_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ctt_source_model (
    // supply conditions chosen by the bench
    input wire logic                plug_in,
    input wire logic                surge,
    input wire logic                drain,
    input wire logic                top_up,
    // comparator levels seen by the block
    output var ctt_pkg::ctt_sense_t sense
);
    // healthy cell always attached, recharge on demand, source follows the plug
    assign sense = '{vbus_above_valid: plug_in, vbus_above_ovp: surge, below_termination: drain,
                     battery_present: 1'b1, source_present: plug_in, battery_weak: 1'b0,
                     recharge_request: top_up};
endmodule // ctt_source_model
`default_nettype wire

// ==== tb/tb_charger_timer_and_termination_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_charger_timer_and_termination_control;
    localparam int QC = 10;
    localparam int TC = 8;
    localparam int RC = 20;
    localparam int AC = 200;
    localparam int UC = 400;
    logic                clk_sys = 1'b0;
    logic                rst_n = 1'b0;
    ctt_pkg::ctt_wr_t    host_wr = '0;
    logic                plug_in = 1'b1;
    logic                surge = 1'b0;
    logic                drain = 1'b0;
    logic                top_up = 1'b0;
    logic                port_select_pin = 1'b0;
    ctt_pkg::ctt_sense_t sense;
    logic                charge_en;
    logic                discharge_load_en;
    logic                stat_pulse;
    logic [1:0]          charge_state;
    logic [2:0]          fault_code;
    ctt_pkg::ctt_regs_t  regs;
    logic [9:0]          charge_thresh_tenth_mv;
    logic [9:0]          term_thresh_tenth_mv;
    logic [1:0]          input_limit_code;
    logic [9:0]          input_limit_ma;
    int                  n_errors = 0;
    int                  checks = 0;
    int                  cyc = 0;
    int                  t0;
    int                  n;
    // free-running clock and cycle count
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    // block under test with shortened timers, and the supply side
    ctt_charger #(.AUTO_START(1'b1), .TERM_STEP_B(1'b0), .TERM_CYC(36'(TC)), .READY_CYC(36'(RC)),
                  .QUAL_CYC(36'(QC)), .ALIVE_CYC(36'(AC)), .UNATT_CYC(36'(UC))) i_ctt_charger (
        .clk_sys(clk_sys), .rst_n(rst_n), .host_wr(host_wr), .sense(sense),
        .port_select_pin(port_select_pin), .charge_en(charge_en), .discharge_load_en(discharge_load_en),
        .stat_pulse(stat_pulse), .charge_state(charge_state), .fault_code(fault_code), .regs(regs),
        .charge_thresh_tenth_mv(charge_thresh_tenth_mv), .term_thresh_tenth_mv(term_thresh_tenth_mv),
        .input_limit_code(input_limit_code), .input_limit_ma(input_limit_ma));
    ctt_source_model i_ctt_source_model (.plug_in(plug_in), .surge(surge), .drain(drain), .top_up(top_up),
                                         .sense(sense));
    // report and stop
    task automatic give_verdict();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // value comparison
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // cycle count must fall inside a window
    task automatic span(input int got, input int lo, input int hi, input string what);
        checks++;
        if (got < lo || got > hi)
        begin
            n_errors++;
            $display("[ERR] %0t %s took %0d cycles", $time, what, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // one register write, valid for a single edge
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        host_wr <= '{valid: 1'b1, index: idx, data: d};
        @(posedge clk_sys);
        host_wr <= '0;
        #1;
    endtask
    // bounded wait: 0 charge_en, 1 charge_state, 2 stat_pulse
    task automatic wait_on(input int sel, input logic [1:0] val, input int max, output int k);
        logic [1:0] cur;
        for (k = 1; k <= max; k++)
        begin
            tick(1);
            cur = (sel == 0) ? {1'b0, charge_en} : (sel == 1) ? charge_state : {1'b0, stat_pulse};
            if (cur === val)
                return;
        end
        n_errors++;
        $display("[ERR] %0t wait %0d ran out", $time, sel);
        give_verdict();
    endtask
    // decoded settings while reset is held
    task automatic t_reset();
        #1;
        cmp(16'(charge_thresh_tenth_mv), 16'(ctt_pkg::ICHG_BASE), "reset ichg");
        cmp(16'(term_thresh_tenth_mv), 16'(ctt_pkg::ITRM_STEP_A), "reset termination_current_code");
        cmp(16'(input_limit_ma), 16'(ctt_pkg::LIM_MA_100), "reset limit");
    endtask
    // boot qualification, interrupted by an unplug and by an overvoltage
    task automatic t_qualify();
        tick(3);
        cmp(16'(discharge_load_en), 16'h0001, "load on");
        @(posedge clk_sys);
        plug_in <= 1'b0;
        tick(2);
        cmp(16'(charge_en), 16'h0000, "no charge");
        @(posedge clk_sys);
        plug_in <= 1'b1;
        // overvoltage sampled on the edge where the count would complete restarts it
        tick(QC - 2);
        @(posedge clk_sys);
        surge <= 1'b1;
        @(posedge clk_sys);
        surge <= 1'b0;
        wait_on(0, 2'h1, QC + 6, n);
        span(n, QC - 1, QC + 2, "qualify");
        t0 = cyc;
    endtask
    // pin limit while unattended, then unattended expiry
    task automatic t_unattended();
        @(posedge clk_sys);
        port_select_pin <= 1'b1;
        tick(3);
        cmp(16'(input_limit_ma), 16'(ctt_pkg::LIM_MA_500), "pin limit");
        @(posedge clk_sys);
        port_select_pin <= 1'b0;
        tick(3);
        cmp(16'(input_limit_ma), 16'(ctt_pkg::LIM_MA_100), "pin limit");
        wait_on(0, 2'h0, UC + 20, n);
        span(cyc - t0, UC - 3, UC + 3, "unattended");
        cmp(16'(fault_code), 16'(ctt_pkg::FAULT_TIMER), "timer fault");
        cmp(16'(regs.charge_disable), 16'h0001, "disable set");
    endtask
    // field decodes written by the host
    task automatic t_decode();
        logic [9:0] lim [4] = '{ctt_pkg::LIM_MA_100, ctt_pkg::LIM_MA_500, ctt_pkg::LIM_MA_800,
                                ctt_pkg::LIM_MA_NONE};
        wr(ctt_pkg::IDX_CONTROL, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            wr(ctt_pkg::IDX_CURRENT, {1'b0, 3'(c), 1'b0, 3'(c)});
            tick(2);
            cmp(16'(charge_thresh_tenth_mv), 16'(ctt_pkg::ICHG_BASE + ctt_pkg::ICHG_STEP * 10'(c)), "ichg");
            cmp(16'(term_thresh_tenth_mv), 16'(ctt_pkg::ITRM_STEP_A * 10'(c + 1)), "termination_current_code");
        end
        for (int c = 0; c < 4; c++)
        begin
            wr(ctt_pkg::IDX_CONTROL, {2'(c), 6'h00});
            tick(2);
            cmp(16'(input_limit_code), 16'(c), "limit code");
            cmp(16'(input_limit_ma), 16'(lim[c]), "limit ma");
        end
    endtask
    // low current ignored until enabled, then ready and done
    task automatic t_terminate();
        wait_on(0, 2'h1, QC + 20, n);
        @(posedge clk_sys);
        drain <= 1'b1;
        tick(TC + 10);
        cmp(16'(charge_state), 16'(ctt_pkg::CS_CHARGE), "no termination");
        wr(ctt_pkg::IDX_CONTROL, 8'h08);
        wait_on(0, 2'h0, TC + 6, n);
        span(n, TC - 2, TC + 3, "qualifier");
        cmp(16'(charge_state), 16'(ctt_pkg::CS_READY), "ready");
        wait_on(1, ctt_pkg::CS_DONE, RC + 6, n);
        span(n, RC - 2, RC + 3, "ready time");
        // recharge demand from done must go back through validation
        @(posedge clk_sys);
        drain <= 1'b0;
        top_up <= 1'b1;
        @(posedge clk_sys);
        top_up <= 1'b0;
        tick(1);
        cmp(16'(discharge_load_en), 16'h0001, "recharge revalidates");
        cmp(16'(charge_en), 16'h0000, "recharge waits");
    endtask
    // kick, then host-alive expiry and default recovery
    task automatic t_alive();
        tick(120);
        wr(ctt_pkg::IDX_STATUS, 8'h80);
        t0 = cyc;
        wait_on(2, 2'h1, AC + 10, n);
        span(cyc - t0, AC - 3, AC + 3, "alive");
        tick(1);
        cmp(16'(stat_pulse), 16'h0000, "one pulse");
        cmp(16'(fault_code), 16'(ctt_pkg::FAULT_TIMER), "alive fault");
        cmp(16'(regs), 16'(ctt_pkg::REGS_DEFAULT), "defaults");
        wait_on(0, 2'h1, QC + 6, n);
        cmp(16'(input_limit_ma), 16'(ctt_pkg::LIM_MA_100), "pin limit again");
    endtask
    // main sequence
    initial
    begin
        repeat (15) @(posedge clk_sys);
        t_reset();
        @(posedge clk_sys);
        rst_n <= 1'b1;
        t_qualify();
        t_unattended();
        t_decode();
        t_terminate();
        t_alive();
        give_verdict();
    end
endmodule // tb_charger_timer_and_termination_control
`default_nettype wire
